// ==== src/pic_map.vh ====
// constants for the snoop versus in-flight command conflict logic
// assumes a 10 MHz system clock and 64-byte cache blocks
// What this block does
// - never send upgrades to nonexistent memory
// - one snoop reply per snoop
// - victim entries keep victim and snoop valids
// - reply reports victim hit and sent state
// - replies leave in snoop arrival order
// - stall snoop on index match in victim file
// - keep one victim entry reserved for snoops
// - victim part of read treated as writeback
// - invalidating snoop on locked block fails conditional store
// - pending reads and claims never interact
// - sent dirty victim hit reported in reply
// - pending upgrade hit reported as miss hit
`ifndef PIC_MAP_VH
`define PIC_MAP_VH
`define PIC_PA_W        44
`define PIC_BLK_LSB     6
`define PIC_IDX_MSB     19
`define PIC_VAF_N       8
`define PIC_VAF_IW      3
`define PIC_MAF_N       8
`define PIC_MAF_IW      3
`define PIC_SQ_N        4
`define PIC_SQ_IW       2
`define PIC_NXT_W       3
// miss entry command kinds
`define PIC_CMD_W       3
`define PIC_CMD_RDBLK   3'h0
`define PIC_CMD_RDMOD   3'h1
`define PIC_CMD_FETCH   3'h2
`define PIC_CMD_CLAIM   3'h3
`define PIC_CMD_UPCLN   3'h4
`define PIC_CMD_UPSHR   3'h5
`define PIC_CMD_UPSTC   3'h6
// next block state codes of a snoop
`define PIC_NXT_INVAL   3'h0
`endif

// ==== src/pic_vaf.v ====
// victim address file: victim and snoop valid bits per entry
// assumes the miss side allocates only when o_alloc_ok is high
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_vaf (
  input  wire                      i_mclk,
  input  wire                      i_resetn,
  input  wire                      i_vic_alloc,
  input  wire [`PIC_PA_W-1:0]      i_vic_pa,
  input  wire                      i_vic_sent,
  input  wire [`PIC_VAF_IW-1:0]    i_vic_sent_idx,
  input  wire                      i_release,
  input  wire [`PIC_VAF_IW-1:0]    i_release_idx,
  input  wire                      i_snp_set,
  input  wire [`PIC_VAF_IW-1:0]    i_snp_set_idx,
  input  wire                      i_snp_clr,
  input  wire [`PIC_VAF_IW-1:0]    i_snp_clr_idx,
  input  wire [`PIC_PA_W-1:0]      i_look_pa,
  output wire                      o_alloc_ok,
  output wire                      o_vic_hit,
  output wire                      o_vic_sent_hit,
  output wire                      o_idx_conflict,
  output wire [`PIC_VAF_N-1:0]     o_vic_valid
);
  reg  [`PIC_PA_W-1:0] pa_reg [0:`PIC_VAF_N-1];
  reg  [`PIC_PA_W-1:0] snp_pa_reg [0:`PIC_VAF_N-1];
  reg  [`PIC_VAF_N-1:0] vic_v_reg;
  reg  [`PIC_VAF_N-1:0] snp_v_reg;
  reg  [`PIC_VAF_N-1:0] sent_reg;
  reg  [`PIC_VAF_IW-1:0] free_idx;
  reg  [`PIC_VAF_IW:0]  free_cnt;
  wire [`PIC_VAF_N-1:0] busy = vic_v_reg | snp_v_reg;
  wire [`PIC_VAF_N-1:0] blk_m;
  wire [`PIC_VAF_N-1:0] idx_m;
  integer k;

  always @* begin
    free_idx = {`PIC_VAF_IW{1'b0}};
    free_cnt = {(`PIC_VAF_IW+1){1'b0}};
    for (k = `PIC_VAF_N-1; k >= 0; k = k - 1) begin
      if (!busy[k]) begin
        free_idx = k[`PIC_VAF_IW-1:0];
        free_cnt = free_cnt + 1'b1;
      end
    end
  end

  assign o_alloc_ok = (free_cnt > 1);

  genvar g;
  generate
    for (g = 0; g < `PIC_VAF_N; g = g + 1) begin : g_ent
      assign blk_m[g] = vic_v_reg[g] &&
        (pa_reg[g][`PIC_PA_W-1:`PIC_BLK_LSB] == i_look_pa[`PIC_PA_W-1:`PIC_BLK_LSB]);
      assign idx_m[g] = snp_v_reg[g] &&
        (snp_pa_reg[g][`PIC_IDX_MSB:`PIC_BLK_LSB] ==
         i_look_pa[`PIC_IDX_MSB:`PIC_BLK_LSB]);
      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          vic_v_reg[g] <= 1'b0;
          snp_v_reg[g] <= 1'b0;
          sent_reg[g]  <= 1'b0;
          pa_reg[g]    <= {`PIC_PA_W{1'b0}};
          snp_pa_reg[g] <= {`PIC_PA_W{1'b0}};
        end else begin
          // victim and snoop valids are kept apart
          if (i_vic_alloc && o_alloc_ok && free_idx == g) begin
            vic_v_reg[g] <= 1'b1;
            sent_reg[g]  <= 1'b0;
            pa_reg[g]    <= i_vic_pa;
          end else if (i_release && i_release_idx == g) begin
            vic_v_reg[g] <= 1'b0;
            sent_reg[g]  <= 1'b0;
          end else if (i_vic_sent && i_vic_sent_idx == g) begin
            sent_reg[g] <= 1'b1;
          end
          if (i_snp_set && i_snp_set_idx == g) begin
            snp_v_reg[g] <= 1'b1;
            // later snoops stall on this snoop's own index, not the victim's
            snp_pa_reg[g] <= i_look_pa;
          end else if (i_snp_clr && i_snp_clr_idx == g) begin
            snp_v_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign o_vic_hit      = |blk_m;
  assign o_vic_sent_hit = |(blk_m & sent_reg);
  assign o_idx_conflict = |idx_m;
  // any held slot, but a victim allocated after slot_reg is picked and before the snoop is taken lands on the same slot
  assign o_vic_valid    = busy;
endmodule // pic_vaf

// ==== src/pic_maf.v ====
// miss address file lookup: finds pending upgrades matching a snoop
// assumes the miss side writes entries and retires them itself
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_maf (
  input  wire                      i_mclk,
  input  wire                      i_resetn,
  input  wire                      i_alloc,
  input  wire [`PIC_MAF_IW-1:0]    i_alloc_idx,
  input  wire [`PIC_PA_W-1:0]      i_alloc_pa,
  input  wire [`PIC_CMD_W-1:0]     i_alloc_cmd,
  input  wire                      i_retire,
  input  wire [`PIC_MAF_IW-1:0]    i_retire_idx,
  input  wire [`PIC_PA_W-1:0]      i_look_pa,
  output wire                      o_upg_hit,
  output wire                      o_stc_hit
);
  reg [`PIC_PA_W-1:0]  pa_reg  [0:`PIC_MAF_N-1];
  reg [`PIC_CMD_W-1:0] cmd_reg [0:`PIC_MAF_N-1];
  reg [`PIC_MAF_N-1:0] v_reg;
  wire [`PIC_MAF_N-1:0] upg_m;
  wire [`PIC_MAF_N-1:0] stc_m;

  // only upgrades interact; reads and write claims do not own the block yet
  function is_upgrade;
    input [`PIC_CMD_W-1:0] c;
    begin
      is_upgrade = (c == `PIC_CMD_UPCLN) || (c == `PIC_CMD_UPSHR) ||
                   (c == `PIC_CMD_UPSTC);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `PIC_MAF_N; g = g + 1) begin : g_ent
      wire blk_eq = pa_reg[g][`PIC_PA_W-1:`PIC_BLK_LSB] ==
                    i_look_pa[`PIC_PA_W-1:`PIC_BLK_LSB];
      assign upg_m[g] = v_reg[g] && blk_eq && is_upgrade(cmd_reg[g]);
      assign stc_m[g] = v_reg[g] && blk_eq && (cmd_reg[g] == `PIC_CMD_UPSTC);
      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          v_reg[g]   <= 1'b0;
          pa_reg[g]  <= {`PIC_PA_W{1'b0}};
          cmd_reg[g] <= `PIC_CMD_RDBLK;
        end else if (i_alloc && i_alloc_idx == g) begin
          v_reg[g]   <= 1'b1;
          pa_reg[g]  <= i_alloc_pa;
          cmd_reg[g] <= i_alloc_cmd;
        end else if (i_retire && i_retire_idx == g) begin
          v_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_upg_hit = |upg_m;
  assign o_stc_hit = |stc_m;
endmodule // pic_maf

// ==== src/pic_top.v ====
// snoop ordering against in-flight miss and victim commands
// assumes the system sends snoops with a valid strobe and takes replies in order
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_top (
  input  wire                      i_mclk,
  input  wire                      i_resetn,
  input  wire                      i_snp_valid,
  input  wire [`PIC_PA_W-1:0]      i_snp_pa,
  input  wire [`PIC_NXT_W-1:0]     i_snp_next,
  output reg                       o_snp_ready,
  output reg                       o_rep_valid,
  output reg                       o_rep_vaf_hit,
  output reg                       o_rep_vic_sent,
  output reg                       o_rep_maf_hit,
  output reg  [`PIC_VAF_IW-1:0]    o_rep_vaf_idx,
  input  wire                      i_snp_done,
  input  wire [`PIC_VAF_IW-1:0]    i_snp_done_idx,
  input  wire                      i_maf_alloc,
  input  wire [`PIC_MAF_IW-1:0]    i_maf_idx,
  input  wire [`PIC_PA_W-1:0]      i_maf_pa,
  input  wire [`PIC_CMD_W-1:0]     i_maf_cmd,
  input  wire                      i_maf_nxm,
  input  wire                      i_maf_retire,
  input  wire [`PIC_MAF_IW-1:0]    i_maf_retire_idx,
  output reg                       o_maf_issue,
  output reg                       o_maf_nxm_fail,
  input  wire                      i_vic_alloc,
  input  wire [`PIC_PA_W-1:0]      i_vic_pa,
  input  wire                      i_vic_sent,
  input  wire [`PIC_VAF_IW-1:0]    i_vic_sent_idx,
  input  wire                      i_release,
  input  wire [`PIC_VAF_IW-1:0]    i_release_idx,
  output reg                       o_vic_alloc_ok,
  input  wire                      i_lock_set,
  input  wire [`PIC_PA_W-1:0]      i_lock_pa,
  input  wire                      i_stc_exec,
  output reg                       o_stc_result,
  output reg                       o_stc_done
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_LOOK  = 2'h1;
  localparam ST_REPLY = 2'h2;

  reg [`PIC_PA_W-1:0]   q_pa_reg   [0:`PIC_SQ_N-1];
  reg [`PIC_NXT_W-1:0]  q_nxt_reg  [0:`PIC_SQ_N-1];
  reg [`PIC_SQ_IW:0]    wp_reg;
  reg [`PIC_SQ_IW:0]    rp_reg;
  reg [1:0]             st_reg;
  reg [1:0]             st_next;
  reg [`PIC_VAF_IW-1:0] slot_reg;
  reg                   lock_v_reg;
  reg [`PIC_PA_W-1:0]   lock_pa_reg;

  wire [`PIC_SQ_IW-1:0] rp  = rp_reg[`PIC_SQ_IW-1:0];
  wire [`PIC_SQ_IW-1:0] wp  = wp_reg[`PIC_SQ_IW-1:0];
  wire q_empty = (wp_reg == rp_reg);
  wire q_full  = (wp_reg[`PIC_SQ_IW-1:0] == rp_reg[`PIC_SQ_IW-1:0]) &&
                 (wp_reg[`PIC_SQ_IW] != rp_reg[`PIC_SQ_IW]);
  wire [`PIC_PA_W-1:0]  head_pa  = q_pa_reg[rp];
  wire [`PIC_NXT_W-1:0] head_nxt = q_nxt_reg[rp];
  wire push = i_snp_valid && o_snp_ready;

  wire vaf_alloc_ok;
  wire vaf_hit;
  wire vaf_sent_hit;
  wire idx_conflict;
  wire [`PIC_VAF_N-1:0] vic_valid;
  wire maf_upg_hit;
  wire maf_stc_hit;
  wire snp_take = (st_reg == ST_LOOK) && !idx_conflict;

  pic_vaf u_vaf (
    .i_mclk         (i_mclk),
    .i_resetn       (i_resetn),
    .i_vic_alloc    (i_vic_alloc),
    .i_vic_pa       (i_vic_pa),
    .i_vic_sent     (i_vic_sent),
    .i_vic_sent_idx (i_vic_sent_idx),
    .i_release      (i_release),
    .i_release_idx  (i_release_idx),
    .i_snp_set      (snp_take),
    .i_snp_set_idx  (slot_reg),
    .i_snp_clr      (i_snp_done),
    .i_snp_clr_idx  (i_snp_done_idx),
    .i_look_pa      (head_pa),
    .o_alloc_ok     (vaf_alloc_ok),
    .o_vic_hit      (vaf_hit),
    .o_vic_sent_hit (vaf_sent_hit),
    .o_idx_conflict (idx_conflict),
    .o_vic_valid    (vic_valid)
  );

  pic_maf u_maf (
    .i_mclk       (i_mclk),
    .i_resetn     (i_resetn),
    .i_alloc      (i_maf_alloc),
    .i_alloc_idx  (i_maf_idx),
    .i_alloc_pa   (i_maf_pa),
    .i_alloc_cmd  (i_maf_cmd),
    .i_retire     (i_maf_retire),
    .i_retire_idx (i_maf_retire_idx),
    .i_look_pa    (head_pa),
    .o_upg_hit    (maf_upg_hit),
    .o_stc_hit    (maf_stc_hit)
  );

  function is_upgrade_cmd;
    input [`PIC_CMD_W-1:0] c;
    begin
      is_upgrade_cmd = (c == `PIC_CMD_UPCLN) || (c == `PIC_CMD_UPSHR) ||
                       (c == `PIC_CMD_UPSTC);
    end
  endfunction

  // snoop queue: replies drain strictly from the head
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_reg <= {(`PIC_SQ_IW+1){1'b0}};
      rp_reg <= {(`PIC_SQ_IW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (st_reg == ST_REPLY) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (push) begin
      q_pa_reg[wp]  <= i_snp_pa;
      q_nxt_reg[wp] <= i_snp_next;
    end
  end

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE:  if (!q_empty) st_next = ST_LOOK;
      // hold the head while an older snoop shares its index
      ST_LOOK:  if (!idx_conflict) st_next = ST_REPLY;
      ST_REPLY: st_next = ST_IDLE;
      default:  st_next = ST_IDLE;
    endcase
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg         <= ST_IDLE;
      o_rep_valid    <= 1'b0;
      o_rep_vaf_hit  <= 1'b0;
      o_rep_vic_sent <= 1'b0;
      o_rep_maf_hit  <= 1'b0;
      o_rep_vaf_idx  <= {`PIC_VAF_IW{1'b0}};
      o_snp_ready    <= 1'b0;
      o_vic_alloc_ok <= 1'b0;
    end else begin
      st_reg         <= st_next;
      o_snp_ready    <= !q_full && !(push && (wp_reg + 1'b1 == {~rp_reg[`PIC_SQ_IW], rp}));
      o_vic_alloc_ok <= vaf_alloc_ok;
      o_rep_valid    <= 1'b0;
      if (snp_take) begin
        // victim hit covers writebacks and victim halves of reads alike
        o_rep_valid    <= 1'b1;
        o_rep_vaf_hit  <= vaf_hit;
        o_rep_vic_sent <= vaf_sent_hit;
        o_rep_maf_hit  <= maf_upg_hit;
        o_rep_vaf_idx  <= slot_reg;
      end
    end
  end

  // the reserved entry leaves a free slot unless an earlier snoop not yet done took it; pick the lowest free one
  integer j;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_v_reg  <= 1'b0;
      lock_pa_reg <= {`PIC_PA_W{1'b0}};
    end else begin
      if (i_lock_set) begin
        lock_v_reg  <= 1'b1;
        lock_pa_reg <= i_lock_pa;
      end
      // invalidating snoop kills the lock, no block-modify read follows
      if (snp_take && head_nxt == `PIC_NXT_INVAL && lock_v_reg &&
          lock_pa_reg[`PIC_PA_W-1:`PIC_BLK_LSB] == head_pa[`PIC_PA_W-1:`PIC_BLK_LSB]) begin
        lock_v_reg <= 1'b0;
      end else if (i_stc_exec) begin
        lock_v_reg <= 1'b0;
      end
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_stc_result   <= 1'b0;
      o_stc_done     <= 1'b0;
      o_maf_issue    <= 1'b0;
      o_maf_nxm_fail <= 1'b0;
    end else begin
      o_stc_done   <= i_stc_exec;
      o_stc_result <= i_stc_exec && lock_v_reg && !(snp_take &&
                      head_nxt == `PIC_NXT_INVAL && lock_pa_reg[`PIC_PA_W-1:`PIC_BLK_LSB]
                      == head_pa[`PIC_PA_W-1:`PIC_BLK_LSB]);
      // upgrades to nonexistent memory are never put on the bus
      o_maf_issue    <= i_maf_alloc && !(i_maf_nxm && is_upgrade_cmd(i_maf_cmd));
      o_maf_nxm_fail <= i_maf_alloc && i_maf_nxm && is_upgrade_cmd(i_maf_cmd);
    end
  end

  // pick a free victim slot for the snoop's data
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      slot_reg <= {`PIC_VAF_IW{1'b0}};
    end else if (st_reg == ST_IDLE) begin
      slot_reg <= {`PIC_VAF_IW{1'b0}};
      for (j = `PIC_VAF_N-1; j >= 0; j = j - 1) begin
        if (!vic_valid[j]) begin
          slot_reg <= j[`PIC_VAF_IW-1:0];
        end
      end
    end
  end
endmodule // pic_top

// ==== dv/pic_top_properties.sv ====
// checker for pic_top: reply pacing, queue limit, nxm upgrades, stc, victim reserve
// assumes one clock domain and victim releases only to occupied slots
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_props (
  input logic                  i_mclk,
  input logic                  i_resetn,
  input logic                  i_snp_valid,
  input logic                  o_snp_ready,
  input logic                  o_rep_valid,
  input logic                  o_rep_vaf_hit,
  input logic                  o_rep_vic_sent,
  input logic                  i_maf_alloc,
  input logic [`PIC_CMD_W-1:0] i_maf_cmd,
  input logic                  i_maf_nxm,
  input logic                  o_maf_issue,
  input logic                  o_maf_nxm_fail,
  input logic                  i_vic_alloc,
  input logic                  i_release,
  input logic                  o_vic_alloc_ok,
  input logic                  i_stc_exec,
  input logic                  o_stc_done,
  input logic                  o_stc_result
);
  logic [2:0] pend_reg;
  logic [3:0] vcnt_reg;
  wire        take = i_snp_valid && o_snp_ready;
  wire        upg  = i_maf_alloc && i_maf_nxm && (i_maf_cmd >= `PIC_CMD_UPCLN);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // victims only: snoop-data slots are not visible at the ports
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_reg <= 3'h0;
      vcnt_reg <= 4'h0;
    end else begin
      pend_reg <= pend_reg + {2'h0, take} - {2'h0, o_rep_valid};
      if (i_vic_alloc && !i_release)
        vcnt_reg <= vcnt_reg + 4'h1;
      else if (i_release && !i_vic_alloc && vcnt_reg != 4'h0)
        vcnt_reg <= vcnt_reg - 4'h1;
    end
  end
  rep_owed_a: assert property (o_rep_valid |-> pend_reg != 3'h0)
    else $error("reply with no snoop owed");
  rep_early_a: assert property (take && pend_reg == 3'h0 |=> !o_rep_valid ##1 !o_rep_valid)
    else $error("reply too early");
  rep_pace_a: assert property (o_rep_valid |=> !o_rep_valid [*2])
    else $error("replies too close");
  queue_full_a: assert property (pend_reg == 3'h4 |-> !o_snp_ready)
    else $error("ready with queue full");
  sent_hit_a: assert property (o_rep_valid && o_rep_vic_sent |-> o_rep_vaf_hit)
    else $error("sent without victim hit");
  nxm_fail_a: assert property (upg |-> ##[1:3] o_maf_nxm_fail)
    else $error("nxm upgrade not refused");
  nxm_quiet_a: assert property (upg |=> !o_maf_issue [*4])
    else $error("nxm upgrade issued");
  stc_done_a: assert property (i_stc_exec |=> o_stc_done)
    else $error("stc not answered");
  vaf_reserve_a: assert property (vcnt_reg >= 4'h7 |-> !o_vic_alloc_ok)
    else $error("last victim slot handed out");
  cover property (!o_snp_ready);
  cover property (o_rep_valid && o_rep_vaf_hit);
  cover property (o_stc_done && !o_stc_result);
  cover property (o_maf_nxm_fail);
endmodule // pic_props

bind pic_top pic_props u_pic_props (
  .i_mclk, .i_resetn, .i_snp_valid, .o_snp_ready, .o_rep_valid, .o_rep_vaf_hit,
  .o_rep_vic_sent, .i_maf_alloc, .i_maf_cmd, .i_maf_nxm, .o_maf_issue, .o_maf_nxm_fail,
  .i_vic_alloc, .i_release, .o_vic_alloc_ok, .i_stc_exec, .o_stc_done, .o_stc_result
);

// ==== dv/pic_sys_model.sv ====
// system side: issues snoops, keeps replies in order, frees buffers
// assumes replies are one-cycle pulses
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_sys_model (
  input  logic                   i_mclk,
  input  logic                   i_snp_ready,
  input  logic                   i_rep_valid,
  input  logic [5:0]             i_rep,
  output logic                   o_snp_valid,
  output logic [`PIC_PA_W-1:0]   o_snp_pa,
  output logic [`PIC_NXT_W-1:0]  o_snp_next,
  output logic                   o_snp_done,
  output logic                   o_release,
  output logic [`PIC_VAF_IW-1:0] o_idx
);
  logic [5:0] rq[$];
  int         n_upg = 0;
  initial begin
    {o_snp_valid, o_snp_pa, o_snp_next, o_snp_done, o_release, o_idx} = '0;
  end
  always @(posedge i_mclk) begin
    if (i_rep_valid)
      rq.push_back(i_rep);
    // a miss hit on an invalidating snoop owes a failed upgrade, never data
    if (i_rep_valid && i_rep[3])
      n_upg++;
  end
  // bb keeps valid up so the next call follows back to back
  task snoop(input logic [43:0] pa, input logic [2:0] nx, input bit bb);
    @(negedge i_mclk);
    o_snp_valid = 1'b1;
    o_snp_pa = pa;
    o_snp_next = nx;
    while (!i_snp_ready)
      @(negedge i_mclk);
    @(posedge i_mclk);
    if (!bb) begin
      @(negedge i_mclk);
      o_snp_valid = 1'b0;
      o_snp_pa = ~pa;
    end
  endtask
  // release commands may come in any order
  task buf_cmd(input bit rel, input logic [2:0] idx);
    @(negedge i_mclk);
    {o_release, o_snp_done, o_idx} = {rel, !rel, idx};
    @(negedge i_mclk);
    {o_release, o_snp_done, o_idx} = {2'h0, ~idx};
  endtask
endmodule // pic_sys_model

// ==== dv/test_probe_inflight_conflict_logic.sv ====
// bench for pic_top: victim conflicts, miss hits, nxm upgrades, locks, victim reserve
// assumes pic_sys_model for the system and pic_props bound to pic_top
`timescale 1ns/1ps
`include "pic_map.vh"
module test_probe_inflight_conflict_logic;
  localparam logic [43:0] PA_V = 44'h000000a0000;
  localparam logic [43:0] PA_M = 44'h0000000b000;
  localparam logic [43:0] PA_L = 44'h00000000c40;
  localparam logic [43:0] PA_F = 44'h00000000d00;
  logic        i_mclk, i_resetn, i_maf_alloc, i_maf_nxm, i_maf_retire, i_vic_alloc;
  logic        i_vic_sent, i_release, i_lock_set, i_stc_exec, i_snp_valid, i_snp_done;
  logic        o_snp_ready, o_rep_valid, o_rep_vaf_hit, o_rep_vic_sent, o_rep_maf_hit;
  logic        o_maf_issue, o_maf_nxm_fail, o_vic_alloc_ok, o_stc_result, o_stc_done;
  logic [43:0] i_snp_pa, i_maf_pa, i_vic_pa, i_lock_pa;
  logic [2:0]  i_snp_next, i_maf_cmd, o_rep_vaf_idx, i_snp_done_idx, i_maf_idx;
  logic [2:0]  i_maf_retire_idx, i_vic_sent_idx, i_release_idx, k;
  int          errors = 0, n_tests = 0, n_iss, n_fail;
  pic_top u_pic_top (
    .i_mclk, .i_resetn, .i_snp_valid, .i_snp_pa, .i_snp_next, .o_snp_ready, .o_rep_valid,
    .o_rep_vaf_hit, .o_rep_vic_sent, .o_rep_maf_hit, .o_rep_vaf_idx, .i_snp_done,
    .i_snp_done_idx, .i_maf_alloc, .i_maf_idx, .i_maf_pa, .i_maf_cmd, .i_maf_nxm,
    .i_maf_retire, .i_maf_retire_idx, .o_maf_issue, .o_maf_nxm_fail, .i_vic_alloc, .i_vic_pa,
    .i_vic_sent, .i_vic_sent_idx, .i_release, .i_release_idx, .o_vic_alloc_ok, .i_lock_set,
    .i_lock_pa, .i_stc_exec, .o_stc_result, .o_stc_done
  );
  pic_sys_model u_sys (
    .i_mclk, .i_snp_ready(o_snp_ready), .i_rep_valid(o_rep_valid),
    .i_rep({o_rep_vaf_hit, o_rep_vic_sent, o_rep_maf_hit, o_rep_vaf_idx}),
    .o_snp_valid(i_snp_valid), .o_snp_pa(i_snp_pa), .o_snp_next(i_snp_next),
    .o_snp_done(i_snp_done), .o_release(i_release), .o_idx(i_snp_done_idx)
  );
  assign i_release_idx = i_snp_done_idx;
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    n_iss += o_maf_issue;
    n_fail += o_maf_nxm_fail;
  end
  task chk(input string n, input logic [5:0] e, input logic [5:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // fields are {victim hit, sent, miss hit}; a missing reply reads as ~e
  task rep(input logic [2:0] e, input bit keep);
    logic [5:0] r;
    repeat (60) if (u_sys.rq.size() == 0) @(negedge i_mclk);
    r = (u_sys.rq.size() != 0) ? u_sys.rq.pop_front() : {~e, 3'h0};
    chk("reply", {3'h0, e}, {3'h0, r[5:3]});
    k = r[2:0];
    if (!keep)
      u_sys.buf_cmd(1'b0, k);
  endtask
  task pulse(input int which, input logic [43:0] pa, input logic [2:0] idx, input logic [3:0] c);
    @(negedge i_mclk);
    {i_maf_pa, i_vic_pa, i_lock_pa} = {pa, pa, pa};
    {i_maf_idx, i_maf_retire_idx, i_vic_sent_idx, i_maf_cmd, i_maf_nxm} = {idx, idx, idx, c};
    {i_maf_alloc, i_maf_retire, i_vic_alloc, i_vic_sent, i_lock_set} = 5'h10 >> which;
    @(negedge i_mclk);
    {i_maf_alloc, i_maf_retire, i_vic_alloc, i_vic_sent, i_lock_set} = 5'h0;
  endtask
  task t_victim;
    pulse(2, PA_V, 3'h0, 4'h0);
    u_sys.snoop(PA_V | 44'h10, 3'h1, 1'b0);
    rep(3'h4, 1'b1);
    u_sys.snoop(PA_V ^ 44'h100000, 3'h0, 1'b0);
    repeat (12) @(negedge i_mclk);
    chk("stall", 6'h0, 6'(u_sys.rq.size()));
    u_sys.buf_cmd(1'b0, k);
    rep(3'h0, 1'b0);
    pulse(3, PA_V, 3'h0, 4'h0);
    u_sys.snoop(PA_V, 3'h0, 1'b0);
    rep(3'h6, 1'b1);
    u_sys.buf_cmd(1'b1, k);
    u_sys.snoop(PA_V ^ 44'h100000, 3'h1, 1'b0);
    repeat (12) @(negedge i_mclk);
    chk("snoop_valid", 6'h0, 6'(u_sys.rq.size()));
    u_sys.buf_cmd(1'b0, k);
    rep(3'h0, 1'b0);
  endtask
  task t_maf;
    for (int c = 0; c < 7; c++) pulse(0, PA_M + (44'(c) << 12), c[2:0], {c[2:0], 1'b0});
    for (int c = 0; c < 7; c++) u_sys.snoop(PA_M + (44'(c) << 12), 3'h0, c < 6);
    for (int c = 0; c < 7; c++) rep({2'h0, c > 3}, 1'b0);
    chk("upg_fail", 6'h03, 6'(u_sys.n_upg));
    for (int c = 0; c < 7; c++) pulse(1, 44'h0, c[2:0], 4'h0);
  endtask
  task t_nxm;
    for (int c = 3; c < 7; c++) begin
      pulse(0, PA_M + (44'(c) << 12), c[2:0], {c[2:0], 1'b1});
      n_iss = 0;
      n_fail = 0;
      repeat (6) @(negedge i_mclk);
      chk("issue", {5'h0, c == 3}, 6'(n_iss));
      chk("nxm_fail", {5'h0, c != 3}, 6'(n_fail));
      pulse(1, 44'h0, c[2:0], 4'h0);
    end
  endtask
  task t_lock;
    for (int c = 0; c < 2; c++) begin
      pulse(4, PA_L, 3'h0, 4'h0);
      u_sys.snoop(PA_L | 44'h8, c[2:0], 1'b0);
      rep(3'h0, 1'b0);
      @(negedge i_mclk);
      i_stc_exec = 1'b1;
      @(negedge i_mclk);
      i_stc_exec = 1'b0;
      chk("stc", {4'h0, 1'b1, c[0]}, {4'h0, o_stc_done, o_stc_result});
    end
  endtask
  task t_full;
    int n;
    for (n = 0; o_vic_alloc_ok && n < 10; n++) pulse(2, PA_F + (44'(n) << 6), 3'h0, 4'h0);
    chk("victims", 6'h07, 6'(n));
    u_sys.snoop(PA_F, 3'h0, 1'b0);
    rep(3'h4, 1'b0);
    for (int i = 7; i >= 0; i--) u_sys.buf_cmd(1'b1, i[2:0]);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {i_maf_alloc, i_maf_nxm, i_maf_retire, i_vic_alloc, i_vic_sent, i_lock_set} = '0;
    {i_maf_idx, i_maf_pa, i_maf_cmd, i_maf_retire_idx, i_vic_pa, i_vic_sent_idx} = '0;
    {i_lock_pa, i_stc_exec, i_resetn, k} = '0;
    repeat (20) @(negedge i_mclk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_mclk);
    t_victim;
    t_maf;
    t_nxm;
    t_lock;
    t_full;
    summarize;
  end
  // the scenarios need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    summarize;
  end
endmodule // test_probe_inflight_conflict_logic
